// [shared/tcr_regs.vh]
// Register offsets, field positions and reset values of the test configuration block
`ifndef TCR_REGS_VH
`define TCR_REGS_VH
`define TCR_OFS_INDEX 8'h1e
`define TCR_ADDR_TSTCFG 12'h078
`define TCR_WIDTH 16
`define TCR_RST_VALUE 16'h0000
`define TCR_RSVD_HI_MSB 15
`define TCR_RSVD_HI_LSB 12
`define TCR_REG_TEST_MSB 11
`define TCR_REG_TEST_LSB 8
`define TCR_BIT_INHIBIT 7
`define TCR_BIT_POR_TEST 6
`define TCR_BIT_RSVD5 5
`define TCR_BIT_SQUEEZE 4
`define TCR_BIT_RSVD3 3
`define TCR_BIT_PUMP_MON 2
`define TCR_BIT_RSVD1 1
`define TCR_BIT_MODULE_MON 0
`define TCR_WRITE_MASK 16'h0fd5
`define TCR_BAL_ENABLE_REG_ADDR 12'h080
`endif

// [rtl/tcr_test_configuration.v]
// Test configuration register bank with APB slave and control outputs
`timescale 1ns/1ns
`include "tcr_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Bits 15:12 reserved; host writes zero, reads always return zero.
// - Bits 11:8 drive the core regulator test; zero means normal.
// - Inhibit bit 7 stops valid packets restarting the comm timeout counter.
// - Bit 6 armed: digital die por trip forces shutdown.
// - Clearing bit 6 does not disarm; only entering shutdown disarms.
// - Bit 4 connects squeeze resistors and redirects balancing enable register.
// - Squeeze on: enable bits drive squeeze resistors; off: balancing outputs.
// - Bit 2 high enables the charge-pump monitor, low disables it.
// - Bit 0 high enables the module voltage monitor, low disables it.
module tcr_test_configuration #(
  parameter CHANNELS = 16
) (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire valid_packet,
  input wire por_trip_pin,
  input wire [CHANNELS-1:0] balancing_enable_register,
  output wire comm_counter_restart,
  output wire shutdown_request,
  input wire shutdown_entered,
  output reg [3:0] core_regulator_test_select,
  output reg comm_counter_reset_inhibit,
  output reg sense_squeeze_enable,
  output reg negative_pump_monitor_enable,
  output reg module_voltage_monitor_enable,
  output reg [CHANNELS-1:0] balance_drive,
  output reg [CHANNELS-1:0] squeeze_drive
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [15:0] cfg_ff;
  reg [15:0] nxt_cfg;
  reg por_armed_ff;
  reg nxt_por_armed;
  reg por_sync1_ff;
  reg por_sync2_ff;
  reg shut_sync1_ff;
  reg shut_sync2_ff;
  reg [31:0] nxt_prdata;
  wire sel_cfg;
  wire wr_en;
  wire rd_setup;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode and data helpers

  // Only the one aligned word of this register answers
  function tcr_hit;
    input [11:0] addr;
    begin
      tcr_hit = (addr == `TCR_ADDR_TSTCFG);
    end
  endfunction

  // Merge written bytes; the word at index 0x1e (byte address 0x078) holds the register in lanes 0 and 1
  function [15:0] tcr_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] strb;
    begin
      tcr_merge = old_val;
      if (strb[0]) tcr_merge[7:0] = new_val[7:0];
      if (strb[1]) tcr_merge[15:8] = new_val[15:8];
      tcr_merge = tcr_merge & `TCR_WRITE_MASK;
    end
  endfunction

  // Register sits in the low half of the bus word; other addresses read zero
  function [31:0] tcr_read_word;
    input hit;
    input [15:0] val;
    begin
      tcr_read_word = {32{1'b0}};
      if (hit) begin
        tcr_read_word[`TCR_WIDTH-1:0] = val;
      end
    end
  endfunction

  assign sel_cfg = tcr_hit(paddr);
  assign wr_en = psel & penable & pwrite & sel_cfg;
  assign rd_setup = psel & ~penable & ~pwrite;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  // Read data is captured in the setup cycle, so the access phase needs no wait state
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage feeds any logic
  always @(posedge sys_clk) begin
    if (rst) begin
      por_sync1_ff <= 1'b0;
      por_sync2_ff <= 1'b0;
      shut_sync1_ff <= 1'b0;
      shut_sync2_ff <= 1'b0;
    end else begin
      por_sync1_ff <= por_trip_pin;
      por_sync2_ff <= por_sync1_ff;
      shut_sync1_ff <= shutdown_entered;
      shut_sync2_ff <= shut_sync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration word
  always @* begin
    nxt_cfg = cfg_ff;
    if (wr_en) begin
      nxt_cfg = tcr_merge(cfg_ff, pwdata[15:0], pstrb[1:0]);
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      cfg_ff <= `TCR_RST_VALUE;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shutdown arming
  // Arming sticks through later clears of bit 6; the shutdown acknowledge drops it.
  // Acknowledge wins over a same-cycle arm, since arming ends on shutdown.
  always @* begin
    nxt_por_armed = por_armed_ff;
    if (nxt_cfg[`TCR_BIT_POR_TEST]) begin
      nxt_por_armed = 1'b1;
    end
    if (shut_sync2_ff) begin
      nxt_por_armed = 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      por_armed_ff <= 1'b0;
    end else begin
      por_armed_ff <= nxt_por_armed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path, held in a flip-flop from the setup cycle through the access phase
  always @* begin
    nxt_prdata = prdata;
    if (rd_setup) begin
      nxt_prdata = tcr_read_word(sel_cfg, cfg_ff);
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      prdata <= {32{1'b0}};
    end else begin
      prdata <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Controls, registered so they never glitch while a write settles
  always @(posedge sys_clk) begin
    if (rst) begin
      core_regulator_test_select <= 4'h0;
      comm_counter_reset_inhibit <= 1'b0;
      sense_squeeze_enable <= 1'b0;
      negative_pump_monitor_enable <= 1'b0;
      module_voltage_monitor_enable <= 1'b0;
    end else begin
      core_regulator_test_select <= cfg_ff[`TCR_REG_TEST_MSB:`TCR_REG_TEST_LSB];
      comm_counter_reset_inhibit <= cfg_ff[`TCR_BIT_INHIBIT];
      sense_squeeze_enable <= cfg_ff[`TCR_BIT_SQUEEZE];
      negative_pump_monitor_enable <= cfg_ff[`TCR_BIT_PUMP_MON];
      module_voltage_monitor_enable <= cfg_ff[`TCR_BIT_MODULE_MON];
    end
  end

  // Each enable bit goes to exactly one of the two drives, never both
  always @(posedge sys_clk) begin
    if (rst) begin
      balance_drive <= {CHANNELS{1'b0}};
      squeeze_drive <= {CHANNELS{1'b0}};
    end else begin
      if (cfg_ff[`TCR_BIT_SQUEEZE]) begin
        squeeze_drive <= balancing_enable_register;
        balance_drive <= {CHANNELS{1'b0}};
      end else begin
        squeeze_drive <= {CHANNELS{1'b0}};
        balance_drive <= balancing_enable_register;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comm counter and shutdown outputs
  // Valid packets restart the timeout counter unless inhibited
  assign comm_counter_restart = valid_packet & ~cfg_ff[`TCR_BIT_INHIBIT];
  assign shutdown_request = por_armed_ff & por_sync2_ff;

endmodule // tcr_test_configuration

// [tb/tcr_test_configuration_properties.sv]
// Port checker for the test configuration register
`timescale 1ns/1ns
module tcr_props #(parameter CHANNELS = 16) (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire valid_packet,
  input wire por_trip_pin,
  input wire [CHANNELS-1:0] balancing_enable_register,
  input wire comm_counter_restart,
  input wire shutdown_request,
  input wire comm_counter_reset_inhibit,
  input wire [CHANNELS-1:0] balance_drive,
  input wire [CHANNELS-1:0] squeeze_drive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr; psel && penable && pwrite && paddr == 12'h078; endsequence
  sequence s_rd; psel && penable && !pwrite && paddr == 12'h078; endsequence
  // Shadow of what the host has written, reserved bits dropped
  logic [15:0] shadow_ff;
  always @(posedge sys_clk) begin
    if (rst) shadow_ff <= 16'h0000;
    else if (psel && penable && pwrite && paddr == 12'h078) begin
      if (pstrb[0]) shadow_ff[7:0] <= pwdata[7:0] & 8'hd5;
      if (pstrb[1]) shadow_ff[15:8] <= pwdata[15:8] & 8'h0f;
    end
  end
  property p_hi; prdata[15:12] == 4'h0; endproperty
  a_hi: assert property (p_hi) else $error("high bits set");
  property p_lo; !(prdata[5] | prdata[3] | prdata[1]); endproperty
  a_lo: assert property (p_lo) else $error("low reserved set");
  property p_rb; s_rd |-> prdata[15:0] == shadow_ff; endproperty
  a_rb: assert property (p_rb) else $error("readback");
  // Inhibit output lags the stored bit by one cycle
  property p_rs; $past(comm_counter_restart) == ($past(valid_packet) && !comm_counter_reset_inhibit); endproperty
  a_rs: assert property (p_rs) else $error("restart");
  property p_mx; !$past(rst) |-> (balance_drive | squeeze_drive) == $past(balancing_enable_register); endproperty
  a_mx: assert property (p_mx) else $error("routing");
  property p_ex; (balance_drive & squeeze_drive) == 0; endproperty
  a_ex: assert property (p_ex) else $error("both drives");
  property p_sd; shutdown_request |-> $past(por_trip_pin, 2); endproperty
  a_sd: assert property (p_sd) else $error("shutdown");
  property p_ct; $rose(comm_counter_reset_inhibit) |-> $past(psel && penable && pwrite, 2); endproperty
  a_ct: assert property (p_ct) else $error("control");
endmodule // tcr_props
bind tcr_test_configuration tcr_props #(.CHANNELS(CHANNELS)) tcr_props_i (.*);

// [tb/tcr_test_configuration_test.sv]
// Self-checking bench for the test configuration register
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_config_register_test;
  logic sys_clk, rst, psel, penable, pwrite, valid_packet, por_trip_pin, shutdown_entered;
  logic [11:0] paddr;
  logic [31:0] pwdata, d, rd, mdl;
  logic [3:0] pstrb, core_regulator_test_select, s;
  logic [15:0] balancing_enable_register, balance_drive, squeeze_drive, b;
  wire pready, pslverr, comm_counter_restart, shutdown_request, comm_counter_reset_inhibit;
  wire sense_squeeze_enable, negative_pump_monitor_enable, module_voltage_monitor_enable;
  wire [31:0] prdata;
  int err_count, checks_done, i;
  tcr_test_configuration tcr_test_configuration_i (.*);
  initial begin sys_clk = 0; forever #50 sys_clk = ~sys_clk; end
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata; psel <= 0; penable <= 0;
  endtask
  initial begin #300000; err_count++; wrap_up; end
  initial begin
    {psel, penable, pwrite, valid_packet, por_trip_pin, shutdown_entered} = 0;
    paddr = 0; pwdata = 0; pstrb = 4'hf; balancing_enable_register = 0; rst = 1;
    d = $urandom(32'hdbc0);
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk); apb(0, 12'h078, 0); `CHK(rd, 32'h0)
    mdl = 0;
    for (i = 0; i < 40; i++) begin
      d = $urandom & 32'h0fd5; b = $urandom; s = $urandom; // Reserved bits written zero
      if (s[0]) mdl[7:0] = d[7:0];
      if (s[1]) mdl[15:8] = d[15:8];
      pstrb <= s;
      @(posedge sys_clk); apb(1, 12'h078, d);
      @(posedge sys_clk); apb(0, 12'h078, 0); `CHK(rd, mdl)
      `CHK(pslverr, 1'b0)
      `CHK({core_regulator_test_select, comm_counter_reset_inhibit, sense_squeeze_enable, negative_pump_monitor_enable, module_voltage_monitor_enable}, {mdl[11:7], mdl[4], mdl[2], mdl[0]})
      valid_packet <= 1; balancing_enable_register <= b;
      @(negedge sys_clk); `CHK(comm_counter_restart, !mdl[7])
      @(posedge sys_clk) valid_packet <= 0;
      @(negedge sys_clk); `CHK({squeeze_drive, balance_drive}, mdl[4] ? {b, 16'h0} : {16'h0, b})
    end
    // Arm, then clear: arming must survive the clear
    pstrb <= 4'hf;
    @(posedge sys_clk); apb(1, 12'h078, 32'h40);
    @(posedge sys_clk); apb(1, 12'h078, 32'h0);
    @(posedge sys_clk); apb(0, 12'h078, 0); `CHK(rd, 32'h0)
    @(posedge sys_clk); apb(1, 12'h07c, 32'hffff);
    @(posedge sys_clk); apb(0, 12'h07c, 0); `CHK(rd, 32'h0)
    por_trip_pin <= 1;
    repeat (4) @(negedge sys_clk); `CHK(shutdown_request, 1'b1)
    shutdown_entered <= 1;
    repeat (4) @(negedge sys_clk); `CHK(shutdown_request, 1'b0)
    wrap_up;
  end
endmodule // test_config_register_test
